//--- common/coherency_unit_defs.svh
`ifndef COHERENCY_UNIT_DEFS_SVH
`define COHERENCY_UNIT_DEFS_SVH

// ****************************************************************
// Register offsets within the unit's register region.
// ****************************************************************
`define CU_OFS_CTRL        8'h00
`define CU_OFS_CONFIG      8'h04
`define CU_OFS_ACCESS      8'h50

// ****************************************************************
// Control register field positions.
// ****************************************************************
`define CU_BIT_ECC_ACCEL   15
`define CU_BIT_ECC_PERIPH  14
`define CU_BIT_ECC_M1      13
`define CU_BIT_ECC_M0      12
`define CU_BIT_IC_STBY     6
`define CU_BIT_UNIT_STBY   5
`define CU_BIT_SPEC_LF     3
`define CU_BIT_RAM_ECC     2
`define CU_BIT_FILTER      1
`define CU_BIT_ENABLE      0

// ****************************************************************
// Reset values and writable masks.
// ****************************************************************
`define CU_CTRL_RESET      32'h0000_0000
`define CU_CTRL_WMASK      32'h0000_f06d
`define CU_ACCESS_RESET    2'h3
`define CU_ACCESS_WMASK    32'h0000_0003

`endif

//--- common/coherency_unit_pkg.sv
`default_nettype none

package coherency_unit_pkg;

    // Register access request from a processor.
    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
        logic        cpu;
    } reg_req_s;

    // Per-processor activity seen by the unit.
    typedef struct packed {
        logic [1:0] wait_for_interrupt_state;
        logic [1:0] pwrdn;
        logic [1:0] req_active;
    } cpu_status_s;

    // Accelerator port handshake inputs.
    typedef struct packed {
        logic arvalid;
        logic awvalid;
        logic wvalid;
        logic core_arready;
        logic core_awready;
        logic core_wready;
    } accel_port_s;

    // Tag lookup events from the coherency pipeline.
    typedef struct packed {
        logic start;
        logic done;
        logic miss;
        logic to_port1;
    } lookup_s;

    typedef enum logic {
        UNIT_RUN,
        UNIT_GATED
    } standby_state_e;

endpackage : coherency_unit_pkg

`default_nettype wire

//--- core/coherency_unit_control_reg.sv
// How it works
// (R01) Bit 15 enables accelerator port ECC checking.
// (R02) Bit 14 enables peripheral master port ECC checking.
// (R03) Bit 13 enables master port one ECC checking.
// (R04) Bit 12 enables master port zero ECC checking.
// (R05) Bit 6 stops idle interrupt controller clock.
// (R06) Bit 5 gates unit clock when fully idle.
// (R07) Gated unit holds accelerator ready outputs low.
// (R08) Processor wake or accelerator request restarts clock.
// (R09) Bit 3 issues speculative linefills with lookup.
// (R10) Lookup miss sends the confirmed linefill.
// (R11) Filtering on: speculative linefills only port zero.
// (R12) Bit 2 enables RAM ECC, resets zero.
// (R13) Without ECC support bit 2 reads zero.
// (R14) Bit 1 shows filter input at reset release.
// (R15) Single master port build reads bit 1 zero.
// (R16) Bit 0 enables the unit, resets zero.
// (R17) Configuration register ignores all writes.
// (R18) Control writes need access control permission.
// (R19) Registers byte writable, reset by unit reset.
// (R20) Reserved control bits read as zero.
`include "coherency_unit_defs.svh"

`default_nettype none

module coherency_unit_control_reg #(
    parameter bit ECC_PRESENT      = 1'b1,
    parameter bit TWO_MASTER_PORTS = 1'b1
) (
    // Clock and reset.
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    // Register access.
    input  wire coherency_unit_pkg::reg_req_s    reg_req,
    output var  logic [31:0]                    reg_rdata,
    output var  logic                           reg_rvalid,
    // Build-time and strap inputs.
    input  wire logic [31:0]                    config_value,
    input  wire logic                           master_filter_enable_input,
    // Activity of the surroundings.
    input  wire coherency_unit_pkg::cpu_status_s cpu_status,
    input  wire logic                           irq_pending,
    input  wire logic                           unit_busy,
    input  wire coherency_unit_pkg::accel_port_s accel_port,
    input  wire coherency_unit_pkg::lookup_s     lookup,
    // ECC and enable controls.
    output var  logic                           ecc_chk_accel,
    output var  logic                           ecc_chk_periph,
    output var  logic                           ecc_chk_master_one,
    output var  logic                           ecc_chk_master_zero,
    output var  logic                           ram_ecc_enable,
    output var  logic                           unit_enable,
    // Clock gating.
    output var  logic                           irq_ctrl_clk_en,
    output var  logic                           unit_clk_en,
    // Accelerator port readies.
    output var  logic                           accel_port_read_addr_ready,
    output var  logic                           accel_port_write_addr_ready,
    output var  logic                           accel_port_write_data_ready,
    // Linefill requests toward the level-2 controller.
    output var  logic                           spec_linefill_master_zero,
    output var  logic                           spec_linefill_master_one,
    output var  logic                           confirmed_linefill,
    output var  logic                           confirmed_was_speculated
);
    import coherency_unit_pkg::*;

    // ****************************************************************
    // Register storage.
    // ****************************************************************
    logic [31:0]    ctrl;
    logic [1:0]     access_ctrl;
    logic           filter_seen;
    logic           filter_captured;
    standby_state_e state;
    standby_state_e next_state;
    logic           spec_pending;

    logic [31:0]    ctrl_wmask;
    logic           ctrl_write;
    logic           access_write;
    logic [31:0]    ctrl_view;

    // Bit 2 is only writable where RAM ECC exists; reserved bits never are.
    assign ctrl_wmask = ECC_PRESENT ? `CU_CTRL_WMASK                       // R13 R20
                                    : (`CU_CTRL_WMASK & ~(32'h1 << `CU_BIT_RAM_ECC));

    // The requesting processor needs its permission bit to change control.
    assign ctrl_write   = reg_req.valid && reg_req.wr && (reg_req.addr == `CU_OFS_CTRL)
                          && access_ctrl[reg_req.cpu];                           // R18
    assign access_write = reg_req.valid && reg_req.wr && (reg_req.addr == `CU_OFS_ACCESS);

    // ****************************************************************
    // Control register, one byte lane per generate step.
    // ****************************************************************
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_ctrl_lane
            // Each lane updates only its own byte, so byte writes work.
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl[lane*8 +: 8] <= 8'(`CU_CTRL_RESET >> (lane*8));             // R19
                end else if (ctrl_write && reg_req.be[lane]) begin
                    ctrl[lane*8 +: 8] <= reg_req.wdata[lane*8 +: 8]
                                         & ctrl_wmask[lane*8 +: 8];                  // R19 R20
                end
            end
        end
    endgenerate

    // Access control permissions, low byte only.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            access_ctrl <= `CU_ACCESS_RESET;                                         // R19
        end else if (access_write && reg_req.be[0]) begin
            access_ctrl <= reg_req.wdata[1:0];
        end
    end

    // ****************************************************************
    // Filter strap capture.
    // ****************************************************************
    // The strap is caught on the first edge after reset release; an async
    // reset may only load a constant, so the capture is a clocked step.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_seen     <= 1'b0;
            filter_captured <= 1'b0;
        end else if (!filter_captured) begin
            filter_seen     <= master_filter_enable_input & TWO_MASTER_PORTS;        // R14 R15
            filter_captured <= 1'b1;
        end
    end

    // Software view of control: stored bits plus the read-only filter bit.
    always_comb begin
        ctrl_view = ctrl & ctrl_wmask;                                               // R20
        ctrl_view[`CU_BIT_FILTER] = filter_seen;                                     // R14
    end

    // ****************************************************************
    // Register read path.
    // ****************************************************************
    // Reads answer one cycle after the request; unmapped offsets read zero.
    // The configuration word only ever feeds the read mux, so it cannot
    // be altered by any write.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.valid && !reg_req.wr;
            if (reg_req.valid && !reg_req.wr) begin
                unique case (reg_req.addr)
                    `CU_OFS_CTRL:   reg_rdata <= ctrl_view;
                    `CU_OFS_CONFIG: reg_rdata <= config_value;                       // R17
                    `CU_OFS_ACCESS: reg_rdata <= {30'h0000_0000, access_ctrl};
                    default:        reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // Static control outputs.
    // ****************************************************************
    // Each enable follows its control bit one cycle after the write.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ecc_chk_accel       <= 1'b0;
            ecc_chk_periph      <= 1'b0;
            ecc_chk_master_one  <= 1'b0;
            ecc_chk_master_zero <= 1'b0;
            ram_ecc_enable      <= 1'b0;
            unit_enable         <= 1'b0;
        end else begin
            ecc_chk_accel       <= ctrl_view[`CU_BIT_ECC_ACCEL];                     // R01
            ecc_chk_periph      <= ctrl_view[`CU_BIT_ECC_PERIPH];                    // R02
            ecc_chk_master_one  <= ctrl_view[`CU_BIT_ECC_M1];                        // R03
            ecc_chk_master_zero <= ctrl_view[`CU_BIT_ECC_M0];                        // R04
            ram_ecc_enable      <= ctrl_view[`CU_BIT_RAM_ECC];                       // R12
            unit_enable         <= ctrl_view[`CU_BIT_ENABLE];                        // R16
        end
    end

    // ****************************************************************
    // Interrupt controller standby.
    // ****************************************************************
    // The clock stays on unless standby is allowed and all is quiet.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ctrl_clk_en <= 1'b1;
        end else begin
            irq_ctrl_clk_en <= !(ctrl_view[`CU_BIT_IC_STBY] && !irq_pending
                                 && (cpu_status.req_active == 2'b00));               // R05
        end
    end

    // ****************************************************************
    // Unit standby state machine.
    // ****************************************************************
    logic all_cpus_idle;
    logic accel_request;

    assign all_cpus_idle = &(cpu_status.wait_for_interrupt_state | cpu_status.pwrdn);
    assign accel_request = accel_port.arvalid || accel_port.awvalid || accel_port.wvalid;

    // Gating needs every idle condition; any wake source reopens the clock.
    always_comb begin
        next_state = state;
        unique case (state)
            UNIT_RUN: begin
                if (ctrl_view[`CU_BIT_UNIT_STBY] && all_cpus_idle
                    && !accel_request && !unit_busy) begin
                    next_state = UNIT_GATED;                                         // R06
                end
            end
            UNIT_GATED: begin
                if (!all_cpus_idle || accel_request || !ctrl_view[`CU_BIT_UNIT_STBY]) begin
                    next_state = UNIT_RUN;                                           // R08
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= UNIT_RUN;
            unit_clk_en <= 1'b1;
        end else begin
            state       <= next_state;
            unit_clk_en <= (next_state == UNIT_RUN);                                 // R06 R08
        end
    end

    // Readies are registered from the next state so they drop in the same
    // cycle the clock enable does; the trade is one cycle of ready latency.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            accel_port_read_addr_ready  <= 1'b0;
            accel_port_write_addr_ready <= 1'b0;
            accel_port_write_data_ready <= 1'b0;
        end else begin
            accel_port_read_addr_ready  <= accel_port.core_arready
                                           && (next_state == UNIT_RUN);              // R07
            accel_port_write_addr_ready <= accel_port.core_awready
                                           && (next_state == UNIT_RUN);              // R07
            accel_port_write_data_ready <= accel_port.core_wready
                                           && (next_state == UNIT_RUN);              // R07
        end
    end

    // ****************************************************************
    // Speculative and confirmed linefills.
    // ****************************************************************
    logic spec_allowed;
    logic spec_to_one;
    logic spec_to_zero;

    // With filtering on, traffic bound for port one gets no speculation.
    assign spec_allowed = lookup.start && ctrl_view[`CU_BIT_SPEC_LF]
                          && ctrl_view[`CU_BIT_ENABLE];                              // R09
    assign spec_to_one  = spec_allowed && lookup.to_port1 && !filter_seen;          // R11
    assign spec_to_zero = spec_allowed && !lookup.to_port1;                          // R11

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            spec_linefill_master_zero <= 1'b0;
            spec_linefill_master_one  <= 1'b0;
        end else begin
            spec_linefill_master_zero <= spec_to_zero;                               // R09
            spec_linefill_master_one  <= spec_to_one;                                // R09 R11
        end
    end

    // Remembers that the fetch for the current lookup was already started.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            spec_pending <= 1'b0;
        end else if (spec_to_zero || spec_to_one) begin
            spec_pending <= 1'b1;
        end else if (lookup.done) begin
            spec_pending <= 1'b0;
        end
    end

    // A miss always sends the confirmed linefill, flagged when speculated.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            confirmed_linefill       <= 1'b0;
            confirmed_was_speculated <= 1'b0;
        end else begin
            confirmed_linefill       <= lookup.done && lookup.miss;                  // R10
            confirmed_was_speculated <= lookup.done && lookup.miss && spec_pending;  // R10
        end
    end

endmodule : coherency_unit_control_reg

`default_nettype wire

//--- tb/coherency_unit_control_reg_properties.sv
`include "coherency_unit_defs.svh"
`default_nettype none

module coherency_unit_control_reg_properties #(
    parameter bit ECC_PRESENT      = 1'b1,
    parameter bit TWO_MASTER_PORTS = 1'b1
) (
    // Clock, reset and register access.
    input wire logic                            ref_clk,
    input wire logic                            rst_n,
    input wire coherency_unit_pkg::reg_req_s    reg_req,
    input wire logic [31:0]                     reg_rdata,
    input wire logic                            reg_rvalid,
    // Surroundings.
    input wire coherency_unit_pkg::cpu_status_s cpu_status,
    input wire logic                            irq_pending,
    input wire logic                            unit_busy,
    input wire coherency_unit_pkg::accel_port_s accel_port,
    input wire coherency_unit_pkg::lookup_s     lookup,
    // Controls driven by the unit.
    input wire logic ecc_chk_accel,
    input wire logic ecc_chk_periph,
    input wire logic ecc_chk_master_one,
    input wire logic ecc_chk_master_zero,
    input wire logic ram_ecc_enable,
    input wire logic unit_enable,
    input wire logic irq_ctrl_clk_en,
    input wire logic unit_clk_en,
    input wire logic accel_port_read_addr_ready,
    input wire logic accel_port_write_addr_ready,
    input wire logic accel_port_write_data_ready,
    input wire logic spec_linefill_master_zero,
    input wire logic spec_linefill_master_one,
    input wire logic confirmed_linefill
);
    timeunit 1ns;
    timeprecision 1ps;
    import coherency_unit_pkg::*;

    // ****************************************************************
    // Sequences and properties.
    // ****************************************************************
    logic all_idle;
    logic wake_req;

    // Idle and wake terms kept combinational so the gating check needs one $past only.
    assign all_idle = !accel_port.arvalid && !accel_port.awvalid && !accel_port.wvalid
                      && !unit_busy && ((cpu_status.wait_for_interrupt_state | cpu_status.pwrdn) == 2'h3);
    assign wake_req = accel_port.arvalid || accel_port.awvalid || accel_port.wvalid
                      || ((cpu_status.wait_for_interrupt_state | cpu_status.pwrdn) != 2'h3);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence ctrl_read_seq;
        reg_rvalid && $past(reg_req.valid && !reg_req.wr && reg_req.addr == `CU_OFS_CTRL);
    endsequence
    sequence gated_wake_seq;
        !unit_clk_en ##0 wake_req;
    endsequence

    enables_follow_a: assert property (ctrl_read_seq |->
        {ecc_chk_accel, ecc_chk_periph, ecc_chk_master_one, ecc_chk_master_zero,
         ram_ecc_enable, unit_enable} == {reg_rdata[15:12], reg_rdata[2], reg_rdata[0]})
        else $error("control outputs differ from the control register");
    reserved_zero_a: assert property (ctrl_read_seq |-> reg_rdata[31:16] == 16'h0000
        && reg_rdata[11:7] == 5'h00 && !reg_rdata[4] && (ECC_PRESENT || !reg_rdata[2]))
        else $error("reserved control bits read nonzero");
    ready_hold_a: assert property (!unit_clk_en |-> !(accel_port_read_addr_ready
        || accel_port_write_addr_ready || accel_port_write_data_ready))
        else $error("accelerator ready high while unit clock gated");
    gate_entry_a: assert property ($fell(unit_clk_en) |-> $past(all_idle))
        else $error("unit clock gated while not idle");
    unit_wake_a: assert property (gated_wake_seq |=> unit_clk_en)
        else $error("unit clock not restarted on wake");
    ic_awake_a: assert property (irq_pending || cpu_status.req_active != 2'h0
        |=> irq_ctrl_clk_en) else $error("interrupt controller clock stopped while busy");
    spec_zero_a: assert property (spec_linefill_master_zero
        |-> $past(lookup.start && !lookup.to_port1)) else $error("stray port zero linefill");
    spec_one_a: assert property (spec_linefill_master_one
        |-> $past(lookup.start && lookup.to_port1)) else $error("stray port one linefill");
    confirm_a: assert property (confirmed_linefill
        |-> $past(lookup.done && lookup.miss)) else $error("confirmed linefill without miss");

endmodule : coherency_unit_control_reg_properties

bind coherency_unit_control_reg coherency_unit_control_reg_properties #(
    .ECC_PRESENT(ECC_PRESENT), .TWO_MASTER_PORTS(TWO_MASTER_PORTS)
) coherency_unit_control_reg_properties_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .cpu_status(cpu_status), .irq_pending(irq_pending),
    .unit_busy(unit_busy), .accel_port(accel_port), .lookup(lookup),
    .ecc_chk_accel(ecc_chk_accel), .ecc_chk_periph(ecc_chk_periph),
    .ecc_chk_master_one(ecc_chk_master_one), .ecc_chk_master_zero(ecc_chk_master_zero),
    .ram_ecc_enable(ram_ecc_enable), .unit_enable(unit_enable),
    .irq_ctrl_clk_en(irq_ctrl_clk_en), .unit_clk_en(unit_clk_en),
    .accel_port_read_addr_ready(accel_port_read_addr_ready),
    .accel_port_write_addr_ready(accel_port_write_addr_ready),
    .accel_port_write_data_ready(accel_port_write_data_ready),
    .spec_linefill_master_zero(spec_linefill_master_zero),
    .spec_linefill_master_one(spec_linefill_master_one),
    .confirmed_linefill(confirmed_linefill)
);

`default_nettype wire

//--- tb/coherency_unit_control_reg_tb.sv
`include "coherency_unit_defs.svh"
`default_nettype none

module coherency_unit_control_reg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import coherency_unit_pkg::*;

    logic        ref_clk = 1'b0;
    logic        rst_n, strap, irqp, busy;
    logic [31:0] cfg, reg_rdata;
    reg_req_s    req;
    cpu_status_s cst;
    accel_port_s ap;
    lookup_s     lk;
    logic reg_rvalid, ecc_a, ecc_p, ecc_1, ecc_0, ram_ecc, uen, ic_en, u_en, rdy_ar, rdy_aw;
    logic rdy_w, spec0, spec1, conf, conf_spec;
    int   n_errors = 0;
    int   check_count = 0;

    // Half period of 2 ns gives the 250 MHz reference clock.
    always #2 ref_clk = ~ref_clk;

    coherency_unit_control_reg #(.ECC_PRESENT(1'b1), .TWO_MASTER_PORTS(1'b1))
    coherency_unit_control_reg_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .config_value(cfg), .master_filter_enable_input(strap),
        .cpu_status(cst), .irq_pending(irqp), .unit_busy(busy), .accel_port(ap),
        .lookup(lk), .ecc_chk_accel(ecc_a), .ecc_chk_periph(ecc_p),
        .ecc_chk_master_one(ecc_1), .ecc_chk_master_zero(ecc_0), .ram_ecc_enable(ram_ecc),
        .unit_enable(uen), .irq_ctrl_clk_en(ic_en), .unit_clk_en(u_en),
        .accel_port_read_addr_ready(rdy_ar), .accel_port_write_addr_ready(rdy_aw),
        .accel_port_write_data_ready(rdy_w), .spec_linefill_master_zero(spec0),
        .spec_linefill_master_one(spec1), .confirmed_linefill(conf),
        .confirmed_was_speculated(conf_spec)
    );

    // ****************************************************************
    // Bus and compare tasks; all stimulus moves on the falling edge.
    // ****************************************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t word got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick

    // A write has no answer, so the request is simply held across one edge.
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                      input logic cpu);
        @(negedge ref_clk);
        req = '{valid: 1'b1, wr: 1'b1, addr: a, be: be, wdata: d, cpu: cpu};
        @(negedge ref_clk);
        req.valid = 1'b0;
    endtask : wr

    // The one-cycle read answer is looked at mid-cycle, while it still stands.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge ref_clk);
        req = '{valid: 1'b1, wr: 1'b0, addr: a, be: 4'hf, wdata: 32'h0, cpu: 1'b0};
        @(negedge ref_clk);
        req.valid = 1'b0;
        chk_bit(reg_rvalid, 1'b1);
        chk_word(reg_rdata, exp);
    endtask : rd

    task automatic lk_pulse(input logic st, input logic dn, input logic ms, input logic p1);
        @(negedge ref_clk);
        lk = '{start: st, done: dn, miss: ms, to_port1: p1};
        @(negedge ref_clk);
        lk = '0;
    endtask : lk_pulse

    task automatic do_reset(input logic s);
        @(negedge ref_clk);
        rst_n = 1'b0;
        strap = s;
        tick(16);
        rst_n = 1'b1;
        tick(2);
    endtask : do_reset

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // ****************************************************************
    // Test sequence.
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        req = '0;
        cst = '0;
        ap = 6'h07;
        lk = '0;
        cfg = 32'h0000_1234;
        strap = 1'b1;
        irqp = 1'b0;
        busy = 1'b0;
        do_reset(1'b1);
        rd(`CU_OFS_CTRL, 32'h0000_0002);
        rd(`CU_OFS_ACCESS, 32'h0000_0003);
        strap = 1'b0;
        wr(`CU_OFS_CTRL, 4'hf, 32'hffff_ffff, 1'b0);
        rd(`CU_OFS_CTRL, 32'h0000_f06f);
        chk_word({26'h0, ecc_a, ecc_p, ecc_1, ecc_0, ram_ecc, uen}, 32'h3f);
        wr(`CU_OFS_CTRL, 4'h2, 32'h0, 1'b0);
        rd(`CU_OFS_CTRL, 32'h0000_006f);
        chk_word({26'h0, ecc_a, ecc_p, ecc_1, ecc_0, ram_ecc, uen}, 32'h03);
        // Processor 0 loses write permission; processor 1 keeps it.
        wr(`CU_OFS_ACCESS, 4'h1, 32'h2, 1'b0);
        wr(`CU_OFS_CTRL, 4'hf, 32'h0, 1'b0);
        rd(`CU_OFS_CTRL, 32'h0000_006f);
        wr(`CU_OFS_CTRL, 4'hf, 32'h0, 1'b1);
        rd(`CU_OFS_CTRL, 32'h0000_0002);
        wr(`CU_OFS_ACCESS, 4'h1, 32'h3, 1'b0);
        wr(`CU_OFS_CONFIG, 4'hf, 32'hffff_ffff, 1'b0);
        rd(`CU_OFS_CONFIG, 32'h0000_1234);
        rd(8'h30, 32'h0);
        // Interrupt controller standby and its wake terms.
        wr(`CU_OFS_CTRL, 4'hf, 32'h41, 1'b0);
        tick(1);
        chk_bit(ic_en, 1'b0);
        irqp = 1'b1;
        tick(2);
        chk_bit(ic_en, 1'b1);
        irqp = 1'b0;
        cst.req_active = 2'h2;
        tick(2);
        chk_bit(ic_en, 1'b1);
        cst.req_active = 2'h0;
        // Unit standby: partial idle, busy, full idle, then two kinds of wake.
        wr(`CU_OFS_CTRL, 4'hf, 32'h21, 1'b0);
        cst.wait_for_interrupt_state = 2'h1;
        tick(2);
        chk_bit(u_en, 1'b1);
        cst.pwrdn = 2'h2;
        busy = 1'b1;
        tick(2);
        chk_bit(u_en, 1'b1);
        busy = 1'b0;
        tick(2);
        chk_word({29'h0, u_en, rdy_ar, rdy_aw}, 32'h0);
        chk_bit(rdy_w, 1'b0);
        ap.arvalid = 1'b1;
        tick(2);
        chk_word({28'h0, u_en, rdy_ar, rdy_aw, rdy_w}, 32'hf);
        ap.arvalid = 1'b0;
        tick(2);
        chk_bit(u_en, 1'b0);
        cst.wait_for_interrupt_state = 2'h0;
        tick(2);
        chk_bit(u_en, 1'b1);
        cst = '0;
        // Linefills without and with speculation, filter captured on.
        wr(`CU_OFS_CTRL, 4'hf, 32'h01, 1'b0);
        lk_pulse(1'b1, 1'b0, 1'b0, 1'b0);
        chk_bit(spec0, 1'b0);
        lk_pulse(1'b0, 1'b1, 1'b1, 1'b0);
        chk_word({30'h0, conf, conf_spec}, 32'h2);
        wr(`CU_OFS_CTRL, 4'hf, 32'h09, 1'b0);
        lk_pulse(1'b1, 1'b0, 1'b0, 1'b0);
        chk_bit(spec0, 1'b1);
        lk_pulse(1'b0, 1'b1, 1'b1, 1'b0);
        chk_word({30'h0, conf, conf_spec}, 32'h3);
        lk_pulse(1'b1, 1'b0, 1'b0, 1'b1);
        chk_bit(spec1, 1'b0);
        // Second reset with the filter strap low lets port one speculate.
        do_reset(1'b0);
        rd(`CU_OFS_CTRL, 32'h0);
        wr(`CU_OFS_CTRL, 4'hf, 32'h09, 1'b0);
        lk_pulse(1'b1, 1'b0, 1'b0, 1'b1);
        chk_bit(spec1, 1'b1);
        finish_test();
    end

    // The sequence needs well under a thousand cycles; this cuts a hang short.
    initial begin
        #20000;
        n_errors++;
        finish_test();
    end

endmodule : coherency_unit_control_reg_tb

`default_nettype wire
